/* rnh_pkg.sv */
// Purpose: Shared constants for the reading null, hold and trigger block
// Assumes: 50 MHz clock, AHB-Lite word registers
// Notes: Reading values are signed 32-bit counts
package rnh_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_NCTL = 8'h04;
  localparam logic [7:0] A_NVAL = 8'h08;
  localparam logic [7:0] A_DNUL = 8'h0c;
  localparam logic [7:0] A_SAMP = 8'h10;
  localparam logic [7:0] A_CMD = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_RSLT = 8'h1c;
  localparam logic [7:0] A_HELD = 8'h20;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int C_REMOTE = 0;
  localparam int C_FUNC = 1;
  localparam int C_CHAN = 3;
  localparam int C_HOLD = 4;
  localparam int C_BAND = 5;
  localparam int C_AUTO = 7;
  localparam int C_DIFF = 8;
  localparam int C_DNAPP = 9;
  localparam int C_FPTRIG = 10;
  localparam int C_RSRC = 12;
  localparam int C_RATIO = 14;
  localparam int CTRL_W = 15;
  localparam logic [14:0] CTRL_RST = 15'h0020;
  localparam logic [1:0] FN_VDC = 2'h0;
  localparam logic [1:0] FN_RES = 2'h1;
  localparam logic [1:0] NM_OFF = 2'h0;
  localparam logic [1:0] NM_ON = 2'h1;
  localparam logic [1:0] NM_ONCE = 2'h2;
  localparam logic [1:0] FP_AUTO = 2'h0;
  localparam logic [1:0] FP_SINGLE = 2'h1;
  localparam logic [1:0] FP_EXT = 2'h2;
  localparam logic [1:0] RS_IMM = 2'h0;
  localparam logic [1:0] RS_BUS = 2'h1;
  localparam logic [1:0] RS_EXT = 2'h2;
  // ----------------------------------------
  // Counts and band divisors
  // ----------------------------------------
  localparam logic [1:0] BAND_RST = 2'h1;
  localparam logic [15:0] SAMP_RST = 16'h0001;
  localparam logic [15:0] SAMP_MAX = 16'hc350;
  localparam logic [1:0] HOLD_LAST = 2'h2;
  localparam logic [13:0] DEN_B0 = 14'h2710;
  localparam logic [13:0] DEN_B1 = 14'h03e8;
  localparam logic [13:0] DEN_B2 = 14'h0064;
  localparam logic [13:0] DEN_B3 = 14'h000a;
  localparam int CLK_HZ = 50000000;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_MEAS} rnh_trig_st_t;

  function automatic logic [32:0] abs33(input logic signed [32:0] v);
    return v[32] ? 33'(-v) : 33'(v);
  endfunction
endpackage

/* rnh_hold_if.sv */
// Purpose: Carries corrected readings to the hold detector and the held value back
// Assumes: One clock domain
// Notes: Top drives the reading side, detector drives held and beep
interface rnh_hold_if;
  logic in_valid;
  logic signed [31:0] in_data;
  logic active;
  logic [1:0] band;
  logic signed [31:0] held;
  logic beep;
  modport det (input in_valid, in_data, active, band, output held, beep);
  modport src (output in_valid, in_data, active, band, input held, beep);
endinterface

/* rnh_hold_det.sv */
// Purpose: Stable-reading detector that freezes the displayed value
// Assumes: Readings arrive as single-cycle strobes
// Notes: Band test is exact, by cross multiplication instead of division
module rnh_hold_det (
  input wire logic clk,
  input wire logic rst,
  rnh_hold_if.det hif
);
  logic signed [31:0] cand_reg;
  logic [1:0] cnt_reg;
  logic signed [31:0] held_reg;
  logic beep_reg;

  // ----------------------------------------
  // Band test
  // ----------------------------------------
  wire [13:0] den = (hif.band == 2'h0) ? rnh_pkg::DEN_B0 :
                    (hif.band == 2'h1) ? rnh_pkg::DEN_B1 :
                    (hif.band == 2'h2) ? rnh_pkg::DEN_B2 : rnh_pkg::DEN_B3;
  wire [32:0] dev = rnh_pkg::abs33(33'(hif.in_data) - 33'(cand_reg));
  wire [32:0] mag = rnh_pkg::abs33(33'(cand_reg));
  wire [46:0] lhs = 47'(dev) * 47'(den);
  wire inb = lhs <= 47'(mag);
  wire take = hif.in_valid & hif.active;

  always_ff @(posedge clk) begin
    beep_reg <= 1'b0;
    if (rst) begin
      cand_reg <= 32'sh0;
      cnt_reg <= 2'h0;
      held_reg <= 32'sh0;
    end else if (!hif.active) begin
      cnt_reg <= 2'h0;
    end else if (take) begin
      if (cnt_reg == 2'h0 || !inb) begin
        cand_reg <= hif.in_data;
        cnt_reg <= 2'h1;
      end else if (cnt_reg == rnh_pkg::HOLD_LAST) begin
        held_reg <= hif.in_data;
        beep_reg <= 1'b1;
        cnt_reg <= 2'h3;
      end else if (cnt_reg == 2'h1) begin
        cnt_reg <= 2'h2;
      end
    end
  end

  assign hif.held = held_reg;
  assign hif.beep = beep_reg;

  // Saturating at three keeps a steady input from beeping on every reading
  a_hold_three: assert property (@(posedge clk) disable iff (rst)
    beep_reg |-> $past(cnt_reg) == 2'h2 && $past(take) && $past(inb))
    else $error("hold beep without three in-band readings");
  a_hold_out_band: assert property (@(posedge clk) disable iff (rst)
    take && !inb |=> cnt_reg == 2'h1 && cand_reg == $past(hif.in_data))
    else $error("out-of-band reading did not restart count");
  a_hold_remote_idle: assert property (@(posedge clk) disable iff (rst)
    !hif.active |=> $stable(held_reg) && !beep_reg)
    else $error("hold acted while inactive");
endmodule // rnh_hold_det

/* rnh_meter.sv */
// Purpose: Null subtraction, reading hold and trigger entry with AHB-Lite registers
// Assumes: Converter returns one rdg_valid strobe per meas_start
// Notes: Writes act in the data phase; reads return zero-wait data
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.

module rnh_meter #(
  parameter int unsigned BLINK_CYC = rnh_pkg::BLINK_CYC,
  parameter logic [31:0] VDC_TOP = 32'h00989680,
  parameter logic [31:0] RES_TOP = 32'h00989680,
  parameter logic [31:0] TMP_TOP = 32'h00989680
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rdg_valid,
  input wire logic signed [31:0] rdg_raw,
  input wire logic rdg_chan,
  input wire logic ext_trig_n,
  output logic meas_start,
  output logic out_valid,
  output logic out_chan,
  output logic signed [31:0] out_data,
  output logic signed [31:0] held_data,
  output logic beep,
  output logic null_lamp,
  output logic range_auto
);
  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wph_reg;
  logic [7:0] adr_reg;
  logic [31:0] hrdata_reg;
  logic [rnh_pkg::CTRL_W-1:0] ctrl_reg;
  logic [15:0] samp_reg;
  logic signed [31:0] dn_reg;
  logic signed [31:0] nv_reg [4];
  logic [3:0] en_reg;
  logic [3:0] val_reg;
  logic [3:0] exp_reg;
  logic err_reg;
  logic signed [31:0] c1_reg;
  logic signed [31:0] out_reg;
  logic out_valid_reg;
  logic out_chan_reg;
  logic lamp_reg;
  logic blink_reg;
  logic [31:0] bl_cnt_reg;
  logic ext_prev_reg;
  logic pend_reg;
  logic start_reg;
  logic [15:0] left_reg;
  logic hold_prev_reg;
  logic auto_lat_reg;
  logic range_auto_reg;
  rnh_pkg::rnh_trig_st_t st_reg;
  rnh_hold_if hif ();

  function automatic logic [1:0] slot_of(input logic [1:0] fn, input logic ch);
    return (fn == rnh_pkg::FN_VDC) ? {1'b0, ch} : (fn == rnh_pkg::FN_RES) ? 2'h2 : 2'h3;
  endfunction

  wire take = hsel & htrans[1] & hready;
  wire hi_ok = haddr[31:8] == 24'h0;
  wire remote = ctrl_reg[rnh_pkg::C_REMOTE];
  wire [1:0] func = ctrl_reg[rnh_pkg::C_FUNC +: 2];
  wire chan = ctrl_reg[rnh_pkg::C_CHAN];
  wire [1:0] band = ctrl_reg[rnh_pkg::C_BAND +: 2];
  wire diff = ctrl_reg[rnh_pkg::C_DIFF];
  wire ratio = ctrl_reg[rnh_pkg::C_RATIO];
  wire dnapp = ctrl_reg[rnh_pkg::C_DNAPP];
  wire [1:0] fptrig = ctrl_reg[rnh_pkg::C_FPTRIG +: 2];
  wire [1:0] rsrc = ctrl_reg[rnh_pkg::C_RSRC +: 2];
  wire busy = st_reg == rnh_pkg::ST_MEAS;
  wire waiting = st_reg == rnh_pkg::ST_WAIT || (!remote && st_reg == rnh_pkg::ST_IDLE);
  wire [31:0] status = {27'h0, err_reg, pend_reg, waiting, busy, lamp_reg};

  wire [31:0] rd_val = !hi_ok ? 32'h0 :
    (haddr[7:0] == rnh_pkg::A_CTRL) ? 32'(ctrl_reg) :
    (haddr[7:0] == rnh_pkg::A_DNUL) ? dn_reg :
    (haddr[7:0] == rnh_pkg::A_SAMP) ? 32'(samp_reg) :
    (haddr[7:0] == rnh_pkg::A_STAT) ? status :
    (haddr[7:0] == rnh_pkg::A_RSLT) ? out_reg :
    (haddr[7:0] == rnh_pkg::A_HELD) ? hif.held : 32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      wph_reg <= 1'b0;
      adr_reg <= 8'h0;
      hrdata_reg <= 32'h0;
    end else begin
      wph_reg <= take & hwrite & hi_ok;
      if (take) begin
        adr_reg <= haddr[7:0];
      end
      if (take & ~hwrite) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  wire wr_ctrl = wph_reg && adr_reg == rnh_pkg::A_CTRL;
  wire wr_nctl = wph_reg && adr_reg == rnh_pkg::A_NCTL;
  wire wr_nval = wph_reg && adr_reg == rnh_pkg::A_NVAL;
  wire wr_dnul = wph_reg && adr_reg == rnh_pkg::A_DNUL;
  wire wr_samp = wph_reg && adr_reg == rnh_pkg::A_SAMP;
  wire wr_cmd = wph_reg && adr_reg == rnh_pkg::A_CMD;
  wire wr_stat = wph_reg && adr_reg == rnh_pkg::A_STAT;
  wire cmd_arm = wr_cmd & hwdata[0];
  wire cmd_bus = wr_cmd & hwdata[1];
  wire cmd_single = wr_cmd & hwdata[2];
  wire ireset = wr_cmd & hwdata[3];
  wire clr = rst | ireset;

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  wire samp_ok = hwdata[15:0] != 16'h0 && hwdata[15:0] <= rnh_pkg::SAMP_MAX && hwdata[31:16] == 16'h0;

  always_ff @(posedge clk) begin
    if (clr) begin
      ctrl_reg <= rnh_pkg::CTRL_RST;
      samp_reg <= rnh_pkg::SAMP_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[rnh_pkg::CTRL_W-1:0];
      end
      if (wr_samp && samp_ok) begin
        samp_reg <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Null storage and correction
  // ----------------------------------------
  wire [31:0] top = (func == rnh_pkg::FN_VDC) ? VDC_TOP :
                    (func == rnh_pkg::FN_RES) ? RES_TOP : TMP_TOP;
  wire [34:0] lim = 35'(top) + 35'(top / 32'd5);
  wire in_lim = 35'(rnh_pkg::abs33(33'(signed'(hwdata)))) <= lim;
  wire [1:0] ws = slot_of(func, chan);
  // Remote writes to a disabled slot are dropped rather than enabling it
  wire nval_ok = in_lim && (!remote || en_reg[ws]);
  wire [1:0] rs = slot_of(func, (diff | ratio) ? rdg_chan : chan);
  wire signed [31:0] rnv = nv_reg[rs];
  wire cap = rdg_valid & en_reg[rs] & ~val_reg[rs];
  wire signed [31:0] corr = cap ? 32'sh0 : en_reg[rs] ? rdg_raw - rnv : rdg_raw;
  wire [1:0] nmode = hwdata[1:0];

  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (clr) begin
        nv_reg[i] <= 32'sh0;
        en_reg[i] <= 1'b0;
        val_reg[i] <= 1'b0;
        exp_reg[i] <= 1'b0;
      end else begin
        if (wr_nval && nval_ok && ws == 2'(i)) begin
          nv_reg[i] <= hwdata;
          val_reg[i] <= 1'b1;
          exp_reg[i] <= 1'b1;
          if (!remote) begin
            en_reg[i] <= 1'b1;
          end
        end else if (cap && rs == 2'(i)) begin
          nv_reg[i] <= rdg_raw;
          val_reg[i] <= 1'b1;
        end
        if (wr_nctl && ws == 2'(i)) begin
          case (nmode)
            rnh_pkg::NM_OFF: begin
              en_reg[i] <= 1'b0;
              val_reg[i] <= exp_reg[i];
            end
            rnh_pkg::NM_ON: begin
              en_reg[i] <= 1'b1;
            end
            rnh_pkg::NM_ONCE: begin
              en_reg[i] <= 1'b1;
              val_reg[i] <= 1'b0;
              exp_reg[i] <= 1'b0;
            end
            default: begin
              en_reg[i] <= en_reg[i];
            end
          endcase
        end
      end
    end
  end

  // Difference null has no remote path
  always_ff @(posedge clk) begin
    if (clr) begin
      dn_reg <= 32'sh0;
      err_reg <= 1'b0;
    end else begin
      if (wr_dnul && !remote && in_lim) begin
        dn_reg <= hwdata;
      end
      if ((wr_nval && !nval_ok) || (wr_dnul && (remote || !in_lim))) begin
        err_reg <= 1'b1;
      end else if (wr_stat && hwdata[4]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Reading output
  // ----------------------------------------
  wire signed [31:0] dsub = (dnapp & diff) ? dn_reg : 32'sh0;
  wire signed [31:0] out_next = (diff && rdg_chan) ? c1_reg - corr - dsub : corr;
  wire emit = rdg_valid & (!diff | rdg_chan);

  always_ff @(posedge clk) begin
    if (rst) begin
      c1_reg <= 32'sh0;
      out_reg <= 32'sh0;
      out_valid_reg <= 1'b0;
      out_chan_reg <= 1'b0;
    end else begin
      out_valid_reg <= emit;
      if (rdg_valid && diff && !rdg_chan) begin
        c1_reg <= corr;
      end
      if (emit) begin
        out_reg <= out_next;
        out_chan_reg <= rdg_chan;
      end
    end
  end

  // ----------------------------------------
  // Null lamp
  // ----------------------------------------
  wire bl_end = bl_cnt_reg >= BLINK_CYC - 1;
  wire dual = diff | ratio;
  wire lamp_next = !dual ? en_reg[ws] : (diff & dnapp) ? 1'b1 :
                   (en_reg[0] | en_reg[1]) ? blink_reg : 1'b0;

  always_ff @(posedge clk) begin
    if (rst) begin
      bl_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
      lamp_reg <= 1'b0;
    end else begin
      bl_cnt_reg <= bl_end ? 32'h0 : bl_cnt_reg + 32'h1;
      blink_reg <= blink_reg ^ bl_end;
      lamp_reg <= lamp_next;
    end
  end

  // ----------------------------------------
  // Reading hold
  // ----------------------------------------
  wire hold_en = ctrl_reg[rnh_pkg::C_HOLD];
  wire hold_act = hold_en & ~remote;
  wire auto_bit = ctrl_reg[rnh_pkg::C_AUTO];

  assign hif.in_valid = out_valid_reg;
  assign hif.in_data = out_reg;
  assign hif.active = hold_act;
  assign hif.band = band;

  rnh_hold_det u_hold (
    .clk(clk),
    .rst(rst),
    .hif(hif)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_prev_reg <= 1'b0;
      auto_lat_reg <= 1'b0;
      range_auto_reg <= 1'b0;
    end else begin
      hold_prev_reg <= hold_en;
      if (hold_en && !hold_prev_reg) begin
        auto_lat_reg <= auto_bit;
      end
      range_auto_reg <= hold_en ? auto_lat_reg : auto_bit;
    end
  end

  // ----------------------------------------
  // Trigger entry
  // ----------------------------------------
  wire ext_edge = ext_prev_reg & ~ext_trig_n;
  wire ext_hit = ext_edge | pend_reg;
  wire fire_loc = !remote && !busy && ((fptrig == rnh_pkg::FP_AUTO) ||
    (fptrig == rnh_pkg::FP_SINGLE && (cmd_single || ext_hit)) ||
    (fptrig == rnh_pkg::FP_EXT && ext_hit));
  wire fire_rem = remote && st_reg == rnh_pkg::ST_WAIT && ((rsrc == rnh_pkg::RS_IMM) ||
    (rsrc == rnh_pkg::RS_BUS && cmd_bus) || (rsrc == rnh_pkg::RS_EXT && ext_hit));
  wire fire = fire_loc | fire_rem;
  wire uses_pend = pend_reg & ((!remote && fptrig != rnh_pkg::FP_AUTO) ||
    (remote && rsrc == rnh_pkg::RS_EXT));
  wire smp_done = busy & emit;

  always_ff @(posedge clk) begin
    start_reg <= 1'b0;
    if (clr) begin
      st_reg <= rnh_pkg::ST_IDLE;
      left_reg <= 16'h0;
      pend_reg <= 1'b0;
      ext_prev_reg <= 1'b1;
    end else begin
      ext_prev_reg <= ext_trig_n;
      if (ext_edge && busy) begin
        pend_reg <= 1'b1;
      end else if (fire && uses_pend) begin
        pend_reg <= 1'b0;
      end
      case (st_reg)
        rnh_pkg::ST_IDLE: begin
          if (fire_loc) begin
            st_reg <= rnh_pkg::ST_MEAS;
            left_reg <= samp_reg;
            start_reg <= 1'b1;
          end else if (remote && cmd_arm) begin
            st_reg <= rnh_pkg::ST_WAIT;
          end
        end
        rnh_pkg::ST_WAIT: begin
          if (fire) begin
            st_reg <= rnh_pkg::ST_MEAS;
            left_reg <= samp_reg;
            start_reg <= 1'b1;
          end else if (!remote) begin
            st_reg <= rnh_pkg::ST_IDLE;
          end
        end
        rnh_pkg::ST_MEAS: begin
          if (smp_done) begin
            if (left_reg <= 16'h1) begin
              st_reg <= rnh_pkg::ST_IDLE;
            end else begin
              left_reg <= left_reg - 16'h1;
              start_reg <= 1'b1;
            end
          end
        end
        default: begin
          st_reg <= rnh_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign meas_start = start_reg;
  assign out_valid = out_valid_reg;
  assign out_chan = out_chan_reg;
  assign out_data = out_reg;
  assign held_data = hif.held;
  assign beep = hif.beep;
  assign null_lamp = lamp_reg;
  assign range_auto = range_auto_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_plain_rdg;
    rdg_valid && !diff && !ratio && en_reg[rs] && val_reg[rs];
  endsequence
  a_null_subtract: assert property (@(posedge clk) disable iff (rst)
    s_plain_rdg |=> out_valid_reg && out_reg == $past(rdg_raw) - $past(rnv))
    else $error("null not subtracted");
  a_null_first_zero: assert property (@(posedge clk) disable iff (clr)
    cap && !diff && !wr_nval && !wr_nctl |=> out_reg == 32'sh0 && val_reg[$past(rs)])
    else $error("first null reading not zero");
  a_null_range: assert property (@(posedge clk) disable iff (clr)
    wr_nval && !in_lim |=> err_reg && $stable(exp_reg))
    else $error("out-of-range null accepted");
  a_null_clear: assert property (@(posedge clk)
    clr |=> en_reg == 4'h0 && val_reg == 4'h0 && band == rnh_pkg::BAND_RST)
    else $error("volatile state not cleared");
  sequence s_fire;
    fire && !clr;
  endsequence
  a_trig_samples: assert property (@(posedge clk) disable iff (clr)
    s_fire |=> start_reg && busy && left_reg == $past(samp_reg))
    else $error("trigger did not start sample burst");
  a_ext_buffer: assert property (@(posedge clk) disable iff (clr)
    ext_edge && busy |=> pend_reg)
    else $error("external trigger lost during reading");
  a_bus_only_wait: assert property (@(posedge clk) disable iff (clr)
    remote && st_reg != rnh_pkg::ST_WAIT |=> !start_reg || $past(busy))
    else $error("remote trigger outside wait state");
  a_lamp_steady: assert property (@(posedge clk) disable iff (rst)
    !dual && en_reg[ws] ##1 !dual && $stable(ws) |-> lamp_reg)
    else $error("null lamp not lit");
endmodule // rnh_meter

/* rnh_conv_model.sv */
// Purpose: Converter model that answers each meas_start with one reading
// Assumes: One clock, readings taken from value at the answering edge
// Notes: Raw lines show the inverse value outside valid, so stale data stands out
module rnh_conv_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic meas_start,
  input wire logic slow,
  input wire logic signed [31:0] value,
  output logic rdg_valid,
  output logic signed [31:0] rdg_raw,
  output logic rdg_chan
);
  logic [3:0] cnt;
  logic busy;
  always_ff @(posedge clk) begin
    rdg_valid <= 1'b0;
    rdg_raw <= ~value;
    rdg_chan <= 1'b1;
    if (rst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
    end else if (meas_start) begin
      busy <= 1'b1;
      cnt <= slow ? 4'h9 : 4'h2;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      rdg_valid <= 1'b1;
      rdg_raw <= value;
      rdg_chan <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // rnh_conv_model

/* rnh_meter_tb.sv */
// Purpose: Self-checking bench for null, hold and trigger entry
// Assumes: Zero-wait slave, converter model on the reading side
// Notes: Blink half period shortened to 4 cycles
module rnh_meter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst = 1;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0] htrans = 0;
  logic hwrite = 0, slow = 0, ext_n = 1;
  logic signed [31:0] val = 0, rdg_raw, out_data, held_data;
  logic hreadyout, hresp, rdg_valid, rdg_chan, meas_start, out_valid, out_chan;
  logic beep, null_lamp, range_auto;
  int errors = 0, cmp_count = 0, cyc = 0, n, k;
  rnh_meter #(.BLINK_CYC(4)) i_dut (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rdg_valid(rdg_valid),
    .rdg_raw(rdg_raw), .rdg_chan(rdg_chan), .ext_trig_n(ext_n), .meas_start(meas_start),
    .out_valid(out_valid), .out_chan(out_chan), .out_data(out_data),
    .held_data(held_data), .beep(beep), .null_lamp(null_lamp), .range_auto(range_auto));
  rnh_conv_model i_conv (.clk(clk), .rst(rst), .meas_start(meas_start), .slow(slow),
    .value(val), .rdg_valid(rdg_valid), .rdg_raw(rdg_raw), .rdg_chan(rdg_chan));
  initial begin
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic nxt(input int cnt);
    repeat (cnt) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (out_valid !== 1'b1 && k < 300);
      if (k == 300) errors++;
    end
  endtask
  task automatic starts(input int cycles);
    n = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (meas_start === 1'b1) n++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_null;
    val <= 5000;
    bus(1, rnh_pkg::A_NVAL, 100);
    nxt(2);
    chk("null out", out_data, 4900);
    chk("lamp", null_lamp, 1);
    bus(1, rnh_pkg::A_NVAL, 12000001);
    bus(0, rnh_pkg::A_STAT, 0);
    chk("err", rd[4], 1);
    bus(1, rnh_pkg::A_NVAL, -12000000);
    nxt(2);
    chk("neg null", out_data, 12005000);
    bus(1, rnh_pkg::A_CTRL, 32'h22);
    bus(1, rnh_pkg::A_NCTL, 1);
    nxt(2);
    chk("capture", out_data, 0);
    val <= 5007;
    nxt(2);
    chk("res slot", out_data, 7);
    bus(1, rnh_pkg::A_NCTL, 2);
    nxt(2);
    chk("once", out_data, 0);
    bus(1, rnh_pkg::A_NCTL, 0);
    nxt(2);
    chk("off", out_data, 5007);
    bus(1, rnh_pkg::A_CTRL, 32'h20);
    nxt(2);
    chk("vdc slot", out_data, 12005007);
    bus(1, rnh_pkg::A_CMD, 8);
    bus(0, rnh_pkg::A_CTRL, 0);
    chk("ctrl", rd, 32'h20);
    nxt(2);
    chk("cleared", out_data, 5007);
    $display("null test done");
  endtask
  task automatic t_hold;
    val <= 1000;
    bus(1, rnh_pkg::A_CTRL, 32'hb0);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (beep !== 1'b1 && k < 300);
    chk("held", held_data, 1000);
    nxt(1);
    val = 2000;
    n = 0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (out_valid === 1'b1) n++;
    end while (beep !== 1'b1 && k < 300);
    chk("new held", held_data, 2000);
    chk("in band", 32'(n), 3);
    bus(1, rnh_pkg::A_CTRL, 32'h30);
    nxt(1);
    chk("range", range_auto, 1);
    $display("hold test done");
  endtask
  task automatic t_remote;
    slow <= 1'b1;
    bus(1, rnh_pkg::A_CTRL, 32'h11);
    val <= 3000;
    bus(1, rnh_pkg::A_SAMP, 3);
    bus(1, rnh_pkg::A_SAMP, 50001);
    bus(0, rnh_pkg::A_SAMP, 0);
    chk("samples", rd, 3);
    repeat (30) @(negedge clk);
    bus(1, rnh_pkg::A_NVAL, 7);
    bus(0, rnh_pkg::A_STAT, 0);
    chk("late null", rd[4], 1);
    bus(1, rnh_pkg::A_NCTL, 1);
    bus(1, rnh_pkg::A_NVAL, 7);
    starts(60);
    chk("no arm", 32'(n), 0);
    bus(1, rnh_pkg::A_CMD, 1);
    starts(150);
    chk("imm burst", 32'(n), 3);
    chk("remote null", out_data, 2993);
    bus(1, rnh_pkg::A_CTRL, 32'h1001);
    bus(1, rnh_pkg::A_CMD, 1);
    starts(40);
    chk("bus wait", 32'(n), 0);
    bus(1, rnh_pkg::A_CMD, 2);
    starts(150);
    chk("bus burst", 32'(n), 3);
    chk("remote hold", held_data, 2000);
    $display("remote test done");
  endtask
  task automatic t_ext;
    bus(1, rnh_pkg::A_CTRL, 32'h820);
    ext_n <= 1'b0;
    @(posedge clk);
    ext_n <= 1'b1;
    repeat (10) @(posedge clk);
    ext_n <= 1'b0;
    @(posedge clk);
    ext_n <= 1'b1;
    starts(150);
    chk("ext bursts", 32'(n), 5);
    bus(1, rnh_pkg::A_CTRL, 32'h420);
    bus(1, rnh_pkg::A_CMD, 4);
    starts(80);
    chk("single", 32'(n), 3);
    $display("trigger test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(0, rnh_pkg::A_SAMP, 0);
    chk("samp rst", rd, 1);
    bus(0, rnh_pkg::A_CTRL, 0);
    chk("ctrl rst", rd, 32'h20);
    t_null();
    t_hold();
    t_remote();
    t_ext();
    wrap_up();
  end
endmodule // rnh_meter_tb
